// *** vts_defines.svh ***
`ifndef VTS_DEFINES_SVH
`define VTS_DEFINES_SVH
`define VTS_ADDR_ATTR    12'h400
`define VTS_ADDR_UNTAG   12'h404
`define VTS_ADDR_FWD     12'h408
`define VTS_ADDR_INDEX   12'h40C
`define VTS_ADDR_CTRL    12'h40E
`define VTS_VALID_BIT    31
`define VTS_FO_BIT       27
`define VTS_PRIO_HI      26
`define VTS_PRIO_LO      24
`define VTS_MST_HI       14
`define VTS_MST_LO       12
`define VTS_FID_HI       6
`define VTS_FID_LO       0
`define VTS_MAP_HI       6
`define VTS_IDX_HI       11
`define VTS_START_BIT    7
`define VTS_ACT_HI       1
`define VTS_DEPTH        4096
`endif

// *** vts_pkg.sv ***
package vts_pkg;
  typedef enum logic [1:0] {
    VTS_ACT_NOP   = 2'h0,
    VTS_ACT_WRITE = 2'h1,
    VTS_ACT_READ  = 2'h2,
    VTS_ACT_CLEAR = 2'h3
  } vts_action_t;
  typedef struct packed {
    logic       valid;
    logic       fwd_sel;
    logic [2:0] prio;
    logic [2:0] mst;
    logic [6:0] filter_identifier;
    logic [6:0] untag;
    logic [6:0] fwd;
  } vts_entry_t;
endpackage

// *** vts_egress.sv ***
`timescale 1ns/1ps
`include "vts_defines.svh"
module vts_egress
  import vts_pkg::*;
(
  // entry fields, plus the map used when fwd_sel is clear
  input  wire logic       valid,
  input  wire logic       fwd_sel,
  input  wire logic [6:0] fwd_map,
  input  wire logic [6:0] other_map,
  // result
  output logic            use_entry,
  output logic [6:0]      egress_map
);
  import vts_pkg::*;
  always_comb begin
    use_entry = valid;
    if (!valid) begin
      egress_map = 7'h00;
    end else if (fwd_sel) begin
      egress_map = fwd_map;
    end else begin
      egress_map = other_map;
    end
  end
endmodule

// *** vts_staging.sv ***
`timescale 1ns/1ps
`include "vts_defines.svh"
//////////////////////////////////////////////////////////////////////////////////
module vts_staging
  import vts_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // register port
  input  wire logic [11:0] reg_addr,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  input  wire logic [31:0] reg_wdata,
  output logic [31:0]      reg_rdata,
  // egress lookup for the entry at lookup_index
  input  wire logic [11:0] lookup_index,
  input  wire logic [6:0]  other_map,
  output logic             lookup_valid,
  output logic [6:0]       lookup_egress,
  output logic [6:0]       lookup_untag,
  output logic [2:0]       lookup_prio,
  output logic [2:0]       lookup_mst,
  output logic [6:0]       lookup_fid,
  // status
  output logic             busy
);
  import vts_pkg::*;

  typedef enum logic [1:0] {VTS_IDLE, VTS_RUN, VTS_CLEAR} vts_state_t;

  vts_entry_t         stage_q, stage_d;
  logic [11:0]        index_q, index_d;
  vts_action_t        act_q, act_d;
  logic               start_q, start_d;
  vts_state_t         state_q, state_d;
  logic [11:0]        clr_q, clr_d;
  vts_entry_t         table_q [`VTS_DEPTH];
  logic               tbl_we;
  logic [11:0]        tbl_addr;
  vts_entry_t         tbl_wdata;
  vts_entry_t         look_q, look_d;
  logic [31:0]        rdata_q, rdata_d;
  logic [6:0]         other_q;

  //////////////////////////////////////////////////////////////////////////////////
  // register writes and table actions
  always_comb begin
    stage_d   = stage_q;
    index_d   = index_q;
    act_d     = act_q;
    start_d   = start_q;
    state_d   = state_q;
    clr_d     = clr_q;
    tbl_we    = 1'b0;
    tbl_addr  = index_q;
    tbl_wdata = stage_q;
    if (reg_write && state_q == VTS_IDLE) begin
      case (reg_addr)
        `VTS_ADDR_ATTR: begin
          stage_d.valid   = reg_wdata[`VTS_VALID_BIT];
          stage_d.fwd_sel = reg_wdata[`VTS_FO_BIT];
          stage_d.prio    = reg_wdata[`VTS_PRIO_HI:`VTS_PRIO_LO];
          stage_d.mst     = reg_wdata[`VTS_MST_HI:`VTS_MST_LO];
          stage_d.filter_identifier     = reg_wdata[`VTS_FID_HI:`VTS_FID_LO];
        end
        `VTS_ADDR_UNTAG: begin
          stage_d.untag = reg_wdata[`VTS_MAP_HI:0];
        end
        `VTS_ADDR_FWD: begin
          stage_d.fwd = reg_wdata[`VTS_MAP_HI:0];
        end
        `VTS_ADDR_INDEX: begin
          index_d = reg_wdata[`VTS_IDX_HI:0];
        end
        `VTS_ADDR_CTRL: begin
          act_d   = vts_action_t'(reg_wdata[`VTS_ACT_HI:0]);
          start_d = reg_wdata[`VTS_START_BIT];
          if (reg_wdata[`VTS_START_BIT]) begin
            state_d = VTS_RUN;
          end
        end
        default: begin
        end
      endcase
    end
    case (state_q)
      VTS_IDLE: begin
      end
      VTS_RUN: begin
        case (act_q)
          VTS_ACT_WRITE: begin
            tbl_we  = 1'b1;
            state_d = VTS_IDLE;
            start_d = 1'b0;
          end
          VTS_ACT_READ: begin
            stage_d = table_q[index_q];
            state_d = VTS_IDLE;
            start_d = 1'b0;
          end
          VTS_ACT_CLEAR: begin
            clr_d   = 12'h000;
            state_d = VTS_CLEAR;
          end
          default: begin
            state_d = VTS_IDLE;
            start_d = 1'b0;
          end
        endcase
      end
      VTS_CLEAR: begin
        // one entry per cycle keeps the table a plain single write port
        tbl_we    = 1'b1;
        tbl_addr  = clr_q;
        tbl_wdata = '0;
        clr_d     = clr_q + 12'h001;
        if (clr_q == 12'hFFF) begin
          state_d = VTS_IDLE;
          start_d = 1'b0;
        end
      end
      default: begin
        state_d = VTS_IDLE;
      end
    endcase
    look_d = table_q[lookup_index];
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      stage_q <= '0;
      index_q <= 12'h000;
      act_q   <= VTS_ACT_NOP;
      start_q <= 1'b0;
      state_q <= VTS_IDLE;
      clr_q   <= 12'h000;
      look_q  <= '0;
      rdata_q <= 32'h0000_0000;
      other_q <= 7'h00;
    end else begin
      stage_q <= stage_d;
      index_q <= index_d;
      act_q   <= act_d;
      start_q <= start_d;
      state_q <= state_d;
      clr_q   <= clr_d;
      look_q  <= look_d;
      rdata_q <= rdata_d;
      other_q <= other_map;
    end
  end

  // table storage holds no reset; software clears it with the clear action
  always_ff @(posedge clock) begin
    if (tbl_we) begin
      table_q[tbl_addr] <= tbl_wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////
  // read-back, one cycle late so read data leaves on a flop
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_read) begin
      case (reg_addr)
        `VTS_ADDR_ATTR: begin
          rdata_d[`VTS_VALID_BIT]            = stage_q.valid;
          rdata_d[`VTS_FO_BIT]               = stage_q.fwd_sel;
          rdata_d[`VTS_PRIO_HI:`VTS_PRIO_LO] = stage_q.prio;
          rdata_d[`VTS_MST_HI:`VTS_MST_LO]   = stage_q.mst;
          rdata_d[`VTS_FID_HI:`VTS_FID_LO]   = stage_q.filter_identifier;
        end
        `VTS_ADDR_UNTAG: rdata_d[`VTS_MAP_HI:0] = stage_q.untag;
        `VTS_ADDR_FWD:   rdata_d[`VTS_MAP_HI:0] = stage_q.fwd;
        `VTS_ADDR_INDEX: rdata_d[`VTS_IDX_HI:0] = index_q;
        `VTS_ADDR_CTRL: begin
          rdata_d[`VTS_START_BIT]  = start_q;
          rdata_d[`VTS_ACT_HI:0]   = act_q;
        end
        default: begin
        end
      endcase
    end
  end

  assign reg_rdata = rdata_q;
  assign busy      = start_q;

  //////////////////////////////////////////////////////////////////////////////////
  // egress decision for looked-up entry
  vts_egress u_egress (
    .valid      (look_q.valid),
    .fwd_sel    (look_q.fwd_sel),
    .fwd_map    (look_q.fwd),
    .other_map  (other_q),
    .use_entry  (lookup_valid),
    .egress_map (lookup_egress)
  );

  always_comb begin
    lookup_untag = look_q.valid ? look_q.untag : 7'h00;
    lookup_prio  = look_q.prio;
    lookup_mst   = look_q.mst;
    lookup_fid   = look_q.filter_identifier;
  end

  //////////////////////////////////////////////////////////////////////////////////
  // checks
  property p_invalid_blocks;
    @(posedge clock) disable iff (reset)
    !look_q.valid |-> (lookup_egress == 7'h00 && !lookup_valid);
  endproperty
  a_invalid_blocks: assert property (p_invalid_blocks) else $error("invalid entry used");

  property p_fwd_map;
    @(posedge clock) disable iff (reset)
    (look_q.valid && look_q.fwd_sel) |-> lookup_egress == look_q.fwd;
  endproperty
  a_fwd_map: assert property (p_fwd_map) else $error("forward map not used");

  property p_other_map;
    @(posedge clock) disable iff (reset)
    (look_q.valid && !look_q.fwd_sel) |-> lookup_egress == other_q;
  endproperty
  a_other_map: assert property (p_other_map) else $error("other map not used");

  property p_prio_wr;
    @(posedge clock) disable iff (reset)
    (reg_write && reg_addr == `VTS_ADDR_ATTR && state_q == VTS_IDLE)
      |=> stage_q.prio == $past(reg_wdata[`VTS_PRIO_HI:`VTS_PRIO_LO]);
  endproperty
  a_prio_wr: assert property (p_prio_wr) else $error("priority not stored");

  property p_rsvd_zero;
    @(posedge clock) disable iff (reset)
    (reg_read && reg_addr == `VTS_ADDR_ATTR)
      |=> (reg_rdata[30:28] == 3'h0 && reg_rdata[23:15] == 9'h000 && reg_rdata[11:7] == 5'h00);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits nonzero");

  property p_map_zero;
    @(posedge clock) disable iff (reset)
    (reg_read && (reg_addr == `VTS_ADDR_UNTAG || reg_addr == `VTS_ADDR_FWD))
      |=> reg_rdata[31:7] == 25'h0000000;
  endproperty
  a_map_zero: assert property (p_map_zero) else $error("map upper bits nonzero");

  property p_write_done;
    @(posedge clock) disable iff (reset)
    (state_q == VTS_RUN && act_q == VTS_ACT_WRITE) |=> (!start_q && state_q == VTS_IDLE);
  endproperty
  a_write_done: assert property (p_write_done) else $error("start not self-cleared");

  property p_read_back;
    @(posedge clock) disable iff (reset)
    (state_q == VTS_RUN && act_q == VTS_ACT_READ) |=> stage_q == $past(table_q[index_q]);
  endproperty
  a_read_back: assert property (p_read_back) else $error("read action failed");
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import vts_pkg::*;
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
  //////////////////////////////////////////////////////////////////////////////
  logic        clock        = 1'b0;
  logic        reset        = 1'b1;
  logic [11:0] reg_addr     = 12'h000;
  logic        reg_write    = 1'b0;
  logic        reg_read     = 1'b0;
  logic [31:0] reg_wdata    = 32'h0;
  logic [31:0] reg_rdata;
  logic [11:0] lookup_index = 12'h000;
  logic [6:0]  other_map    = 7'h00;
  logic        lookup_valid;
  logic [6:0]  lookup_egress;
  logic [6:0]  lookup_untag;
  logic [2:0]  lookup_prio;
  logic [2:0]  lookup_mst;
  logic [6:0]  lookup_fid;
  logic        busy;
  int          n_fail       = 0;
  int          n_checks     = 0;
  logic [6:0]  eg;
  // entries: forward option set, forward option clear, invalid
  logic [11:0] e_idx [3]    = '{12'h005, 12'h006, 12'h007};
  logic [31:0] e_attr [3]   = '{32'h8D00302A, 32'h8200401D, 32'h0B001001};
  logic [6:0]  e_untag [3]  = '{7'h15, 7'h41, 7'h7F};
  logic [6:0]  e_fwd [3]    = '{7'h6A, 7'h7F, 7'h33};
  logic [11:0] r_addr [6]   = '{12'h400, 12'h404, 12'h408, 12'h40C, 12'h40E, 12'h410};
  logic [31:0] r_full [6]   = '{32'h8F00707F, 32'h7F, 32'h7F, 32'hFFF, 32'h0, 32'h0};
  //////////////////////////////////////////////////////////////////////////////
  vts_staging DUT (
    .clock         (clock),
    .reset         (reset),
    .reg_addr      (reg_addr),
    .reg_write     (reg_write),
    .reg_read      (reg_read),
    .reg_wdata     (reg_wdata),
    .reg_rdata     (reg_rdata),
    .lookup_index  (lookup_index),
    .other_map     (other_map),
    .lookup_valid  (lookup_valid),
    .lookup_egress (lookup_egress),
    .lookup_untag  (lookup_untag),
    .lookup_prio   (lookup_prio),
    .lookup_mst    (lookup_mst),
    .lookup_fid    (lookup_fid),
    .busy          (busy)
  );
  initial begin
    forever #25 clock = ~clock;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // one idle edge between writes so reg_write never toggles twice in a step
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    `CHK($sformatf("rdata %h", a), e, reg_rdata)
  endtask
  // clear of the whole table runs about 4100 cycles
  task automatic wait_idle();
    for (int k = 0; k < 5000; k++) begin
      @(posedge clock);
      #1;
      if (busy === 1'b0) begin
        return;
      end
    end
    n_fail++;
    summarize();
  endtask
  task automatic lk(input logic [11:0] i, input logic [6:0] o);
    @(posedge clock);
    lookup_index <= i;
    other_map <= o;
    @(posedge clock);
    #1;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(r_addr[i], 32'h0);
    end
    for (int i = 0; i < 5; i++) begin
      wr(r_addr[i], (i == 4) ? 32'h0 : 32'hFFFFFFFF);
      rd(r_addr[i], r_full[i]);
    end
    wr(12'h410, 32'hFFFFFFFF);
    rd(12'h410, 32'h0);
    // table is not reset, so clear it first; staging write while busy is dropped
    wr(12'h40E, 32'h83);
    rd(12'h40E, 32'h83);
    `CHK("busy", 1'b1, busy)
    wr(12'h400, 32'h12345678);
    wait_idle();
    rd(12'h40E, 32'h03);
    rd(12'h400, 32'h8F00707F);
    lk(12'hFFF, 7'h55);
    `CHK("clr valid", 1'b0, lookup_valid)
    `CHK("clr egress", 7'h00, lookup_egress)
    for (int i = 0; i < 3; i++) begin
      wr(12'h400, e_attr[i]);
      wr(12'h404, {25'h0, e_untag[i]});
      wr(12'h408, {25'h0, e_fwd[i]});
      wr(12'h40C, {20'h0, e_idx[i]});
      wr(12'h40E, 32'h81);
      wait_idle();
    end
    for (int i = 0; i < 3; i++) begin
      eg = !e_attr[i][31] ? 7'h00 : (e_attr[i][27] ? e_fwd[i] : 7'h55);
      lk(e_idx[i], 7'h55);
      `CHK("valid", e_attr[i][31], lookup_valid)
      `CHK("egress", eg, lookup_egress)
      `CHK("untag", e_attr[i][31] ? e_untag[i] : 7'h00, lookup_untag)
      if (e_attr[i][31]) begin
        `CHK("prio", e_attr[i][26:24], lookup_prio)
        `CHK("mst", e_attr[i][14:12], lookup_mst)
        `CHK("fid", e_attr[i][6:0], lookup_fid)
      end
      // read back through staging after wiping it
      wr(12'h400, 32'h0);
      wr(12'h404, 32'h0);
      wr(12'h408, 32'h0);
      wr(12'h40C, {20'h0, e_idx[i]});
      wr(12'h40E, 32'h82);
      wait_idle();
      rd(12'h400, e_attr[i]);
      rd(12'h404, {25'h0, e_untag[i]});
      rd(12'h408, {25'h0, e_fwd[i]});
    end
    wr(12'h40E, 32'h80);
    wait_idle();
    rd(12'h40E, 32'h00);
    rd(12'h400, e_attr[2]);
    summarize();
  end
endmodule
